// ===== rtl/ext_mem_clk_strobe.sv
// Clock source selection, output clocks and shared strobe pins
`timescale 1ns/1ps
`default_nettype none
`include "ext_mem_defines.svh"
module ext_mem_clk_strobe (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ext_clock_in,
  input wire logic [1:0] clock_select_straps,
  input wire logic [1:0] div_ratio,
  input wire logic bus_release,
  input wire logic read_enable_select,
  input wire logic acc_active,
  input wire logic [1:0] acc_kind,
  input wire logic [1:0] acc_space,
  input wire logic req_read,
  input wire logic req_column,
  input wire logic req_addr,
  input wire logic req_oe,
  input wire logic req_row,
  input wire logic req_write,
  output logic undivided_clock_out,
  output logic undivided_clock_oe,
  output logic divided_clock_out,
  output logic divided_clock_oe,
  output logic [1:0] clock_source,
  output logic strobe_a_n,
  output logic strobe_a_oe,
  output logic strobe_b_n,
  output logic strobe_b_oe,
  output logic write_enable_n,
  output logic write_enable_oe,
  output logic fifo_space_output_enable_n,
  output logic fifo_space_output_enable_oe
);
  div_if div4_bus ();
  div_if div6_bus ();

  core_clk_div #(.HALF(`DIV4_HALF)) u_div4 (
    .mclk(mclk),
    .srst(srst),
    .out(div4_bus)
  );

  core_clk_div #(.HALF(`DIV6_HALF)) u_div6 (
    .mclk(mclk),
    .srst(srst),
    .out(div6_bus)
  );

  // Pin synchronisers
  logic ext_s1;
  logic ext_s2;
  logic [1:0] strap_s1;
  logic [1:0] strap_s2;

  always_ff @(posedge mclk) begin
    if (srst) begin
      ext_s1 <= 1'h0;
      ext_s2 <= 1'h0;
      strap_s1 <= 2'h0;
      strap_s2 <= 2'h0;
    end else begin
      ext_s1 <= ext_clock_in;
      ext_s2 <= ext_s1;
      strap_s1 <= clock_select_straps;
      strap_s2 <= strap_s1;
    end
  end

  // Strap capture once after reset release
  ext_mem_pkg::clk_src_t sel;
  ext_mem_pkg::clk_src_t next_sel;
  logic captured;
  logic next_captured;
  logic [1:0] settle;
  logic [1:0] next_settle;

  always_comb begin
    next_sel = sel;
    next_captured = captured;
    next_settle = settle;
    if (!captured) begin
      if (settle == `STRAP_SETTLE) begin
        next_captured = 1'h1;
        case (strap_s2)
          `STRAP_CORE_DIV4: next_sel = ext_mem_pkg::SRC_DIV4;
          `STRAP_CORE_DIV6: next_sel = ext_mem_pkg::SRC_DIV6;
          default: next_sel = ext_mem_pkg::SRC_EXT;
        endcase
      end else begin
        next_settle = settle + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sel <= ext_mem_pkg::SRC_EXT;
      captured <= 1'h0;
      settle <= `CNT_RESET;
    end else begin
      sel <= next_sel;
      captured <= next_captured;
      settle <= next_settle;
    end
  end

  // Interface clock level and output clocks
  logic iface_lvl;
  logic iface_prev;
  logic iface_rise;
  logic [1:0] div_cnt;
  logic [1:0] next_div_cnt;
  logic next_divided;

  always_comb begin
    case (sel)
      ext_mem_pkg::SRC_DIV4: iface_lvl = div4_bus.level;
      ext_mem_pkg::SRC_DIV6: iface_lvl = div6_bus.level;
      default: iface_lvl = ext_s2;
    endcase
  end

  assign iface_rise = iface_lvl && !iface_prev;

  always_comb begin
    next_div_cnt = div_cnt;
    if (iface_rise) begin
      next_div_cnt = div_cnt + 2'h1;
    end
    case (ext_mem_pkg::div_ratio_t'(div_ratio))
      ext_mem_pkg::RATIO_1: next_divided = iface_lvl;
      ext_mem_pkg::RATIO_2: next_divided = next_div_cnt[0];
      default: next_divided = next_div_cnt[1];
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      iface_prev <= 1'h0;
      div_cnt <= `CNT_RESET;
      undivided_clock_out <= 1'h0;
      divided_clock_out <= 1'h0;
    end else begin
      iface_prev <= iface_lvl;
      div_cnt <= next_div_cnt;
      undivided_clock_out <= iface_lvl;
      divided_clock_out <= next_divided;
    end
  end

  assign clock_source = sel;

  // Shared strobe pins, active low
  logic next_a;
  logic next_b;
  logic next_w;
  logic next_fifo;
  logic next_oe;

  always_comb begin
    next_a = `STROBE_IDLE;
    next_b = `STROBE_IDLE;
    next_w = `STROBE_IDLE;
    next_fifo = `STROBE_IDLE;
    next_oe = !bus_release;
    if (acc_active) begin
      case (ext_mem_pkg::mem_kind_t'(acc_kind))
        ext_mem_pkg::MEM_ASYNC: begin
          next_a = !req_read;
          next_b = !req_oe;
          next_w = !req_write;
        end
        ext_mem_pkg::MEM_SDRAM: begin
          next_a = !req_column;
          next_b = !req_row;
          next_w = !req_write;
        end
        ext_mem_pkg::MEM_SYNC: begin
          next_a = read_enable_select ? !req_read : !req_addr;
          next_b = !req_oe;
          next_w = !req_write;
          if (acc_space == `FIFO_SPACE) begin
            next_fifo = !req_oe;
          end
        end
        default: begin
          next_a = `STROBE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      strobe_a_n <= `STROBE_IDLE;
      strobe_b_n <= `STROBE_IDLE;
      write_enable_n <= `STROBE_IDLE;
      fifo_space_output_enable_n <= `STROBE_IDLE;
      strobe_a_oe <= 1'h0;
    end else begin
      strobe_a_n <= next_a;
      strobe_b_n <= next_b;
      write_enable_n <= next_w;
      fifo_space_output_enable_n <= next_fifo;
      strobe_a_oe <= next_oe;
    end
  end

  assign strobe_b_oe = strobe_a_oe;
  assign write_enable_oe = strobe_a_oe;
  assign fifo_space_output_enable_oe = strobe_a_oe;
  assign undivided_clock_oe = strobe_a_oe;
  assign divided_clock_oe = strobe_a_oe;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  strap_div4_sel_a: assert property (
    !captured && settle == `STRAP_SETTLE && strap_s2 == `STRAP_CORE_DIV4
      |=> sel == ext_mem_pkg::SRC_DIV4 && captured)
    else $error("core/4 strap not selected");

  strap_default_sel_a: assert property (
    !captured && settle == `STRAP_SETTLE && strap_s2 == `STRAP_EXT_CLOCK
      |=> sel == ext_mem_pkg::SRC_EXT)
    else $error("default strap did not pick external clock");

  div_two_toggle_a: assert property (
    iface_rise && div_ratio == 2'b01 && $past(div_ratio) == 2'b01
      |=> divided_clock_out != $past(divided_clock_out))
    else $error("divide by two output missed a toggle");

  // External pin reaches the output after two sync stages and the output flop
  undiv_follow_a: assert property (
    captured && sel == ext_mem_pkg::SRC_EXT |-> undivided_clock_out == $past(ext_clock_in, 3))
    else $error("undivided clock does not follow input clock");

  async_read_pin_a: assert property (
    acc_active && acc_kind == 2'b00 |=> strobe_a_n == !$past(req_read))
    else $error("async read enable wrong on shared pin");

  sync_strobe_pick_a: assert property (
    acc_active && acc_kind == 2'b10 && !read_enable_select
      |=> strobe_a_n == !$past(req_addr))
    else $error("sync address strobe not on shared pin");

  sdram_row_pin_a: assert property (
    acc_active && acc_kind == 2'b01 |=> strobe_b_n == !$past(req_row))
    else $error("sdram row strobe wrong on shared pin");

  write_pin_a: assert property (
    acc_active && acc_kind != 2'b11 |=> write_enable_n == !$past(req_write))
    else $error("write enable wrong on shared pin");

  fifo_space_only_a: assert property (
    !fifo_space_output_enable_n |-> $past(acc_space) == `FIFO_SPACE && $past(acc_active)
      && $past(acc_kind) == 2'b10)
    else $error("fifo output enable outside space three");

  sel_fixed_a: assert property (
    captured |=> $stable(sel) [*4])
    else $error("clock selection changed after capture");
endmodule
`default_nettype wire

// ===== include/ext_mem_defines.svh
// Constants for the narrow external memory clock and strobe block
`ifndef EXT_MEM_DEFINES_SVH
`define EXT_MEM_DEFINES_SVH

// Strap codes on clock_select_straps
`define STRAP_EXT_CLOCK 2'h0
`define STRAP_CORE_DIV4 2'h1
`define STRAP_CORE_DIV6 2'h2
`define STRAP_SPARE 2'h3

// Core clock division ratios and the matching half periods in mclk cycles
`define CORE_DIV4 4
`define CORE_DIV6 6
`define DIV4_HALF 3'h2
`define DIV6_HALF 3'h3

// Synchroniser settle count before the straps are captured
`define STRAP_SETTLE 2'h2

// Chip-enable space that owns the FIFO output enable
`define FIFO_SPACE 2'h3

// Reset values
`define CNT_RESET 2'h0
`define STROBE_IDLE 1'h1
`endif

// ===== include/ext_mem_pkg.sv
// Types for the narrow external memory clock and strobe block
package ext_mem_pkg;

  typedef enum logic [1:0] {
    SRC_EXT = 2'b00,
    SRC_DIV4 = 2'b01,
    SRC_DIV6 = 2'b10
  } clk_src_t;

  typedef enum logic [1:0] {
    MEM_ASYNC = 2'b00,
    MEM_SDRAM = 2'b01,
    MEM_SYNC = 2'b10,
    MEM_NONE = 2'b11
  } mem_kind_t;

  typedef enum logic [1:0] {
    RATIO_1 = 2'b00,
    RATIO_2 = 2'b01,
    RATIO_4 = 2'b10,
    RATIO_4B = 2'b11
  } div_ratio_t;

endpackage

// ===== include/div_if.sv
// Square wave handed from a core clock divider to the clock selector
`timescale 1ns/1ps
`default_nettype none
interface div_if;
  logic level;
  modport src (output level);
  modport dst (input level);
endinterface
`default_nettype wire

// ===== rtl/core_clk_div.sv
// Divides mclk by twice HALF into a square wave level
`timescale 1ns/1ps
`default_nettype none
`include "ext_mem_defines.svh"
module core_clk_div #(
  parameter logic [2:0] HALF = `DIV4_HALF
) (
  input wire logic mclk,
  input wire logic srst,
  div_if.src out
);
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic lvl;
  logic next_lvl;

  always_comb begin
    next_cnt = cnt + 3'h1;
    next_lvl = lvl;
    if (cnt == HALF - 3'h1) begin
      next_cnt = 3'h0;
      next_lvl = ~lvl;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt <= 3'h0;
      lvl <= 1'h0;
    end else begin
      cnt <= next_cnt;
      lvl <= next_lvl;
    end
  end

  assign out.level = lvl;

  // Level holds between half-period boundaries
  half_period_a: assert property (@(posedge mclk) disable iff (srst)
    (cnt != HALF - 3'h1) |=> $stable(lvl))
    else $error("divider level changed inside a half period");
endmodule
`default_nettype wire

// ===== tb/strap_clock_source.sv
// Strap resistors and free-running external interface clock source
`timescale 1ns/1ps
`default_nettype none
module strap_clock_source #(
  parameter int EXT_HALF_NS = 200
) (
  input wire logic [1:0] strap_code,
  output logic ext_clock_in,
  output logic [1:0] clock_select_straps
);
  // Free-running interface clock, slow enough to be sampled
  initial begin
    ext_clock_in = 1'b0;
    forever #(EXT_HALF_NS) ext_clock_in = ~ext_clock_in;
  end
  // Pull resistors hold their level
  assign clock_select_straps = strap_code;
endmodule
`default_nettype wire

// ===== tb/ext_mem_clk_strobe_tb.sv
// Self-checking bench for the clock selection and shared strobe block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module ext_mem_clk_strobe_tb;
  logic mclk, srst, ext_clock_in, read_enable_select, acc_active, bus_release;
  logic req_read, req_column, req_addr, req_oe, req_row, req_write;
  logic [1:0] clock_select_straps, div_ratio, acc_kind, acc_space, strap_code, clock_source;
  logic undivided_clock_out, undivided_clock_oe, divided_clock_out, divided_clock_oe;
  logic strobe_a_n, strobe_a_oe, strobe_b_n, strobe_b_oe, write_enable_n, write_enable_oe;
  logic fifo_space_output_enable_n, fifo_space_output_enable_oe;
  int err_total, comparisons;

  strap_clock_source partner (.strap_code, .ext_clock_in, .clock_select_straps);
  ext_mem_clk_strobe dut (.mclk, .srst, .ext_clock_in, .clock_select_straps, .div_ratio,
    .bus_release, .read_enable_select, .acc_active, .acc_kind, .acc_space, .req_read,
    .req_column, .req_addr, .req_oe, .req_row, .req_write, .undivided_clock_out,
    .undivided_clock_oe, .divided_clock_out, .divided_clock_oe, .clock_source, .strobe_a_n,
    .strobe_a_oe, .strobe_b_n, .strobe_b_oe, .write_enable_n, .write_enable_oe,
    .fifo_space_output_enable_n, .fifo_space_output_enable_oe);

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic report_and_stop;
    $display("Totals: comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] code);
    @(posedge mclk);
    strap_code <= code;
    srst <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    `CHK("reset strobe", 1'b1, strobe_a_n)
    `CHK("reset oe", 1'b0, strobe_a_oe)
    @(posedge mclk);
    srst <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask

  task automatic count_rises(output int nu, output int nd);
    logic pu, pd;
    nu = 0;
    nd = 0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    pu = undivided_clock_out;
    pd = divided_clock_out;
    repeat (48) begin
      @(negedge mclk);
      if (undivided_clock_out && !pu) nu++;
      if (divided_clock_out && !pd) nd++;
      pu = undivided_clock_out;
      pd = divided_clock_out;
    end
  endtask

  task automatic test_straps;
    int nu, nd;
    for (int c = 0; c < 4; c++) begin
      do_reset(c[1:0]);
      count_rises(nu, nd);
      `CHK("source", (c == 1) ? 2'h1 : (c == 2) ? 2'h2 : 2'h0, clock_source)
      `CHK("undiv rises", (c == 1) ? 12 : (c == 2) ? 8 : 6, nu)
      `CHK("div1 rises", (c == 1) ? 12 : (c == 2) ? 8 : 6, nd)
    end
    $display("Test straps done");
  endtask

  task automatic test_strap_hold;
    int nu, nd;
    do_reset(2'h1);
    strap_code <= 2'h2;
    count_rises(nu, nd);
    `CHK("held source", 2'h1, clock_source)
    `CHK("held rises", 12, nu)
    $display("Test strap hold done");
  endtask

  task automatic test_ratio;
    int nu, nd;
    for (int r = 0; r < 4; r++) begin
      @(posedge mclk);
      div_ratio <= r[1:0];
      count_rises(nu, nd);
      `CHK("div rises", (r == 0) ? 12 : (r == 1) ? 6 : 3, nd)
    end
    $display("Test ratio done");
  endtask

  task automatic test_strobes;
    logic [5:0] q;
    logic ea, eb, ew, ef;
    for (int i = 0; i < 192; i++) begin
      q = 6'h01 << (i % 6);
      @(posedge mclk);
      acc_active <= i[7];
      acc_kind <= i[4:3];
      read_enable_select <= i[5];
      acc_space <= {2{i[6]}};
      {req_read, req_column, req_addr, req_oe, req_row, req_write} <= q;
      @(posedge mclk);
      @(negedge mclk);
      ea = acc_active && (acc_kind == 2'h0 ? q[5] : acc_kind == 2'h1 ? q[4] :
        acc_kind == 2'h2 ? (read_enable_select ? q[5] : q[3]) : 1'b0);
      eb = acc_active && (acc_kind == 2'h1 ? q[1] : acc_kind != 2'h3 && q[2]);
      ew = acc_active && acc_kind != 2'h3 && q[0];
      ef = acc_active && acc_kind == 2'h2 && acc_space == 2'h3 && q[2];
      `CHK("pin a", !ea, strobe_a_n)
      `CHK("pin b", !eb, strobe_b_n)
      `CHK("pin w", !ew, write_enable_n)
      `CHK("fifo oe", !ef, fifo_space_output_enable_n)
    end
    @(posedge mclk);
    acc_active <= 1'b0;
    $display("Test strobes done");
  endtask

  task automatic test_release;
    logic [5:0] oes;
    @(posedge mclk);
    bus_release <= 1'b1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    oes = {undivided_clock_oe, divided_clock_oe, strobe_a_oe, strobe_b_oe, write_enable_oe,
      fifo_space_output_enable_oe};
    `CHK("released oe", 6'h00, oes)
    @(posedge mclk);
    bus_release <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK("driven oe", 1'b1, fifo_space_output_enable_oe)
    $display("Test release done");
  endtask

  initial begin
    #3000000;
    err_total++;
    report_and_stop();
  end

  initial begin
    err_total = 0;
    comparisons = 0;
    srst = 1'b1;
    strap_code = 2'h0;
    {div_ratio, acc_kind, acc_space} = 6'h00;
    {bus_release, read_enable_select, acc_active} = 3'h0;
    {req_read, req_column, req_addr, req_oe, req_row, req_write} = 6'h00;
    @(posedge mclk);
    test_straps();
    test_strap_hold();
    test_ratio();
    test_strobes();
    test_release();
    report_and_stop();
  end
endmodule
`default_nettype wire
